// file: src/color_pixel_pipeline.sv
// color pixel pipeline: mosaic interpolation, colour matrix, yuv, hue/saturation, sharpening
// assumes sensor samples, register port and packetiser all run on i_sys_clk
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module color_pixel_pipeline
  import color_pipe_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_pix_valid,
  input  wire logic        i_line_start,
  input  wire logic        i_frame_start,
  input  wire logic [11:0] i_pix_data,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  output logic             o_pix_valid,
  output logic      [2:0]  o_pix_format,
  output logic      [7:0]  o_comp0,
  output logic      [7:0]  o_comp1,
  output logic      [7:0]  o_comp2,
  output logic      [11:0] o_raw_sample
);

  // ==========================================================================
  // helpers
  function automatic logic [7:0] clip8(input logic signed [47:0] x);
    if (x < 0) clip8 = 8'h00;
    else if (x > 48'sh0000_0000_00FF) clip8 = 8'hFF;
    else clip8 = x[7:0];
  endfunction

  function automatic logic is_raw(input fmt_t f);
    is_raw = (f == mosaic_byte_format) || (f == mosaic_packed_format) ||
             (f == mosaic_word_format);
  endfunction

  function automatic logic [7:0] ccm_row(input logic signed [31:0] k0, input logic signed [31:0] k1,
                                         input logic signed [31:0] k2, input logic [7:0] r,
                                         input logic [7:0] g, input logic [7:0] b);
    logic signed [47:0] acc;
    acc = 48'(k0) * 48'($signed({1'b0, r})) + 48'(k1) * 48'($signed({1'b0, g})) +
          48'(k2) * 48'($signed({1'b0, b}));
    ccm_row = clip8((acc * RECIP_1000) >>> RECIP_SH);
  endfunction

  function automatic logic signed [47:0] wsum(input logic signed [9:0] kr,
                                              input logic signed [9:0] kg,
                                              input logic signed [9:0] kb,
                                              input logic signed [9:0] r,
                                              input logic signed [9:0] g,
                                              input logic signed [9:0] b);
    wsum = (48'(kr) * 48'(r) + 48'(kg) * 48'(g) + 48'(kb) * 48'(b)) >>> YUV_SH;
  endfunction

  // ==========================================================================
  // register state
  logic        [8:0]  hue_q, hue_d, sat_q, sat_d;
  logic        [2:0]  sharp_q, sharp_d;
  fmt_t               fmt_q, fmt_d;
  logic               ccm_en_q, ccm_en_d, set_sel_q, set_sel_d;
  logic signed [31:0] user_q [COEF_NUM];
  logic signed [31:0] user_d [COEF_NUM];
  logic signed [31:0] coef   [COEF_NUM];
  logic        [31:0] rdata_q, rdata_d;
  logic        [15:0] line_cnt_q, line_cnt_d;
  logic               busy;
  logic               coef_hit;
  logic        [3:0]  cidx, rbase;
  logic signed [31:0] others, capped;

  pix_t s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, s4_q, s4_d, s5_q, s5_d, lf_q, lf_d, out_q, out_d;

  assign busy     = s1_q.v | s2_q.v | s3_q.v | s4_q.v | s5_q.v;
  assign coef_hit = (i_reg_addr >= COEF_OFS) && (i_reg_addr <= COEF_END) &&
                    (i_reg_addr[1:0] == 2'h0);
  assign cidx     = 4'((i_reg_addr - COEF_OFS) >> 2);

  always_comb begin
    for (int k = 0; k < COEF_NUM; k++) begin
      coef[k] = set_sel_q ? user_q[k] : FACTORY_COEF[k];
    end
  end

  always_comb begin
    hue_d     = hue_q;
    sat_d     = sat_q;
    sharp_d   = sharp_q;
    fmt_d     = fmt_q;
    ccm_en_d  = ccm_en_q;
    set_sel_d = set_sel_q;
    user_d    = user_q;
    rdata_d   = 32'h0000_0000;
    rbase     = (cidx >= 4'(2 * CCM_N)) ? 4'(2 * CCM_N) : (cidx >= 4'(CCM_N)) ? 4'(CCM_N) : 4'h0;
    others    = COEF_ZERO;
    for (int k = 0; k < CCM_N; k++) begin
      if (rbase + 4'(k) != cidx) others = others + user_q[rbase + 4'(k)];
    end
    capped = $signed(i_reg_wdata);
    if (capped < COEF_MIN) capped = COEF_MIN;
    if (capped > COEF_MAX) capped = COEF_MAX;
    if (capped > ROW_MAX - others) capped = ROW_MAX - others;
    if (i_reg_wr) begin
      if (i_reg_addr == HUE_OFS) begin
        hue_d = (i_reg_wdata > 32'(HUE_MAX)) ? HUE_MAX : i_reg_wdata[8:0];
      end else if (i_reg_addr == SAT_OFS) begin
        sat_d = (i_reg_wdata > 32'(SAT_MAX)) ? SAT_MAX : i_reg_wdata[8:0];
      end else if (i_reg_addr == CTRL_OFS) begin
        fmt_d     = (i_reg_wdata[FMT_LSB +: 3] > 3'(mosaic_word_format)) ? yuv_pixel_format :
                    fmt_t'(i_reg_wdata[FMT_LSB +: 3]);
        ccm_en_d  = i_reg_wdata[CCM_EN_BIT];
        sharp_d   = (i_reg_wdata[SHARP_LSB +: 3] > SHARP_MAX) ? SHARP_MAX :
                    i_reg_wdata[SHARP_LSB +: 3];
        set_sel_d = i_reg_wdata[SET_SEL_BIT];
      end else if (coef_hit) begin
        user_d[cidx] = capped;
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr == HUE_OFS) rdata_d = 32'(hue_q);
      else if (i_reg_addr == SAT_OFS) rdata_d = 32'(sat_q);
      else if (i_reg_addr == CTRL_OFS) begin
        rdata_d[FMT_LSB +: 3]    = fmt_q;
        rdata_d[CCM_EN_BIT]      = ccm_en_q;
        rdata_d[SHARP_LSB +: 3]  = sharp_q;
        rdata_d[SET_SEL_BIT]     = set_sel_q;
      end else if (i_reg_addr == STAT_OFS) begin
        rdata_d[15:0]     = line_cnt_q;
        rdata_d[BUSY_BIT] = busy;
      end else if (coef_hit) rdata_d = user_q[cidx];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hue_q     <= HUE_RST;
      sat_q     <= SAT_RST;
      sharp_q   <= SHARP_RST;
      fmt_q     <= yuv_pixel_format;
      ccm_en_q  <= 1'b1;
      set_sel_q <= 1'b0;
      user_q    <= FACTORY_COEF;
      rdata_q   <= 32'h0000_0000;
    end else begin
      hue_q     <= hue_d;
      sat_q     <= sat_d;
      sharp_q   <= sharp_d;
      fmt_q     <= fmt_d;
      ccm_en_q  <= ccm_en_d;
      set_sel_q <= set_sel_d;
      user_q    <= user_d;
      rdata_q   <= rdata_d;
    end
  end

  // ==========================================================================
  // line store and 2x2 interpolation
  logic [7:0]       lbuf_q [LINE_MAX];
  logic [7:0]       lbuf_d [LINE_MAX];
  logic [COL_W-1:0] col_q, col_d, curcol;
  logic             rowp_q, rowp_d, currow;
  logic [7:0]       tl_q, tl_d, bl_q, bl_d, tr, br;
  logic [8:0]       gsum;

  assign curcol = i_line_start ? '0 : col_q + 1'b1;
  assign currow = i_frame_start ? 1'b0 : (i_line_start ? ~rowp_q : rowp_q);
  assign tr     = lbuf_q[curcol];
  assign br     = i_pix_data[11:4];

  always_comb begin
    lbuf_d     = lbuf_q;
    col_d      = col_q;
    rowp_d     = rowp_q;
    tl_d       = tl_q;
    bl_d       = bl_q;
    line_cnt_d = line_cnt_q;
    gsum       = 9'h000;
    s1_d       = '0;
    s1_d.v     = i_pix_valid;
    s1_d.sol   = i_line_start;
    s1_d.fmt   = fmt_q;
    s1_d.raw   = i_pix_data;
    if (i_pix_valid) begin
      lbuf_d[curcol] = br;
      col_d          = curcol;
      rowp_d         = currow;
      tl_d           = tr;
      bl_d           = br;
      if (i_frame_start) line_cnt_d = 16'h0001;
      else if (i_line_start) line_cnt_d = line_cnt_q + 16'h0001;
    end
    // even row, even column holds red
    case ({currow, curcol[0]})
      2'b00: begin
        gsum = {1'b0, bl_q} + {1'b0, tr};
        s1_d.c0 = 10'(br);
        s1_d.c2 = 10'(tl_q);
      end
      2'b01: begin
        gsum = {1'b0, br} + {1'b0, tl_q};
        s1_d.c0 = 10'(bl_q);
        s1_d.c2 = 10'(tr);
      end
      2'b10: begin
        gsum = {1'b0, br} + {1'b0, tl_q};
        s1_d.c0 = 10'(tr);
        s1_d.c2 = 10'(bl_q);
      end
      default: begin
        gsum = {1'b0, bl_q} + {1'b0, tr};
        s1_d.c0 = 10'(tl_q);
        s1_d.c2 = 10'(br);
      end
    endcase
    s1_d.c1 = 10'(gsum[8:1]);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      lbuf_q     <= '{default: 8'h00};
      col_q      <= '0;
      rowp_q     <= 1'b0;
      tl_q       <= 8'h00;
      bl_q       <= 8'h00;
      line_cnt_q <= 16'h0000;
    end else begin
      lbuf_q     <= lbuf_d;
      col_q      <= col_d;
      rowp_q     <= rowp_d;
      tl_q       <= tl_d;
      bl_q       <= bl_d;
      line_cnt_q <= line_cnt_d;
    end
  end

  // ==========================================================================
  // matrix, yuv, hue/saturation, sharpening
  logic signed [47:0] hd, sn, cs, un, vn, yl, yr, yacc, sat48;
  logic               ccm_on;

  assign ccm_on = ccm_en_q && !is_raw(s1_q.fmt);

  always_comb begin
    s2_d = s1_q;
    if (ccm_on) begin
      s2_d.c0 = 10'(ccm_row(coef[0], coef[1], coef[2], s1_q.c0[7:0], s1_q.c1[7:0], s1_q.c2[7:0]));
      s2_d.c1 = 10'(ccm_row(coef[3], coef[4], coef[5], s1_q.c0[7:0], s1_q.c1[7:0], s1_q.c2[7:0]));
      s2_d.c2 = 10'(ccm_row(coef[6], coef[7], coef[8], s1_q.c0[7:0], s1_q.c1[7:0], s1_q.c2[7:0]));
    end
    s3_d = s2_q;
    if (s2_q.fmt == yuv_pixel_format) begin
      s3_d.c0 = 10'(clip8(wsum(Y_R, Y_G, Y_B, s2_q.c0, s2_q.c1, s2_q.c2)));
      s3_d.c1 = 10'(wsum(U_R, U_G, U_B, s2_q.c0, s2_q.c1, s2_q.c2));
      s3_d.c2 = 10'(wsum(V_R, V_G, V_B, s2_q.c0, s2_q.c1, s2_q.c2));
    end
    // rotation about grey keeps neutral colours neutral
    hd    = 48'($signed({1'b0, hue_q}) - HUE_MID);
    sn    = hd * SIN_K;
    cs    = COS_ONE - ((hd * hd * COS_K) >>> COS_SH);
    sat48 = 48'($signed({1'b0, sat_q}));
    un    = ((48'(s3_q.c1) * cs - 48'(s3_q.c2) * sn) * sat48) >>> HS_SH;
    vn    = ((48'(s3_q.c1) * sn + 48'(s3_q.c2) * cs) * sat48) >>> HS_SH;
    s4_d = s3_q;
    if (s3_q.fmt == yuv_pixel_format) begin
      s4_d.c1 = 10'(clip8(un + CHROMA_OFS));
      s4_d.c2 = 10'(clip8(vn + CHROMA_OFS));
    end
    s5_d = s4_q;
    lf_d = s5_q;
    // a missing neighbour is replaced by the centre sample
    yl   = (lf_q.v && !s5_q.sol) ? 48'(s5_q.c0 + lf_q.c0) : 48'(s5_q.c0 + s5_q.c0);
    yr   = (s4_q.v && !s4_q.sol) ? 48'(s4_q.c0) : 48'(s5_q.c0);
    yacc = (48'(SHARP_SIDE[sharp_q]) * (yl - 48'(s5_q.c0) + yr) +
            48'(SHARP_MID[sharp_q]) * 48'(s5_q.c0)) >>> SHARP_SH;
    out_d = s5_q;
    if (s5_q.fmt == yuv_pixel_format) out_d.c0 = 10'(clip8(yacc));
    if (is_raw(s5_q.fmt)) begin
      out_d.c0 = (s5_q.fmt == mosaic_byte_format) ? 10'(s5_q.raw[11:4]) : 10'sh000;
      out_d.c1 = 10'sh000;
      out_d.c2 = 10'sh000;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      s4_q  <= '0;
      s5_q  <= '0;
      lf_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      s4_q  <= s4_d;
      s5_q  <= s5_d;
      lf_q  <= lf_d;
      out_q <= out_d;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_pix_valid  = out_q.v;
  assign o_pix_format = out_q.fmt;
  assign o_comp0      = out_q.c0[7:0];
  assign o_comp1      = out_q.c1[7:0];
  assign o_comp2      = out_q.c2[7:0];
  assign o_raw_sample = out_q.raw;

  // ==========================================================================
  // checks
  logic [2:0] rst_age_q;
  logic       coef_ok, row_ok;
  logic signed [31:0] rsum;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) rst_age_q <= 3'h0;
    else if (rst_age_q != 3'(PIPE_LAT + 1)) rst_age_q <= rst_age_q + 3'h1;
  end

  always_comb begin
    coef_ok = 1'b1;
    row_ok  = 1'b1;
    rsum    = COEF_ZERO;
    for (int k = 0; k < COEF_NUM; k++) begin
      if (user_q[k] < COEF_MIN || user_q[k] > COEF_MAX) coef_ok = 1'b0;
    end
    for (int r = 0; r < CCM_N; r++) begin
      rsum = user_q[r * CCM_N] + user_q[r * CCM_N + 1] + user_q[r * CCM_N + 2];
      if (rsum > ROW_MAX) row_ok = 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_fixed_latency: assert property (
    rst_age_q == 3'(PIPE_LAT + 1) |-> o_pix_valid == $past(i_pix_valid, 6))
    else $error("output valid not six cycles after input valid");
  a_raw_passthru: assert property (
    rst_age_q == 3'(PIPE_LAT + 1) && o_pix_valid && is_raw(fmt_t'(o_pix_format))
    |-> o_raw_sample == $past(i_pix_data, 6))
    else $error("raw sample altered");
  a_raw_no_color: assert property (
    o_pix_valid && is_raw(fmt_t'(o_pix_format)) |-> o_comp1 == 8'h00 && o_comp2 == 8'h00)
    else $error("colour data present in raw output");
  a_hue_range: assert property (hue_q <= HUE_MAX)
    else $error("hue beyond 256");
  a_coef_range: assert property (coef_ok)
    else $error("coefficient outside -1000..2000");
  a_row_cap: assert property (row_ok)
    else $error("matrix row sum above 2000");
  a_ccm_bypass: assert property (
    s1_q.v && !ccm_en_q ##1 s2_q.v |-> s2_q.c0 == $past(s1_q.c0) && s2_q.c2 == $past(s1_q.c2))
    else $error("matrix not bypassed when disabled");
  a_sharp_neutral: assert property (
    s5_q.v && s5_q.fmt == yuv_pixel_format && sharp_q == SHARP_RST
    |=> o_comp0 == $past(s5_q.c0[7:0]))
    else $error("level two sharpness changed luma");
  a_sat_grey: assert property (
    s3_q.v && s3_q.fmt == yuv_pixel_format && sat_q == 9'h000
    |=> s4_q.c1 == 10'(CHROMA_OFS) && s4_q.c2 == 10'(CHROMA_OFS))
    else $error("zero saturation left chroma");

  c_yuv_out: cover property (o_pix_valid && o_pix_format == yuv_pixel_format);
  c_rgb_out: cover property (o_pix_valid && o_pix_format == direct_rgb_byte_format);
  c_raw_out: cover property (o_pix_valid && o_pix_format == mosaic_byte_format);
  c_coef_wr: cover property (i_reg_wr && coef_hit ##1 set_sel_q);

endmodule // color_pixel_pipeline

// file: src/color_pipe_pkg.sv
// color pixel pipeline: register map, field layout, arithmetic constants, pixel record
// assumes a single pixel clock shared by sensor readout, packetiser and register port
package color_pipe_pkg;

  // ==========================================================================
  // geometry and latency
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned COL_W    = 10;
  localparam int unsigned LINE_MAX = 1024;
  localparam int unsigned CCM_N    = 3;
  localparam int unsigned COEF_NUM = 9;
  localparam int unsigned PIPE_LAT = 6;

  // ==========================================================================
  // register map and fields
  localparam logic [11:0] HUE_OFS  = 12'h0810;
  localparam logic [11:0] SAT_OFS  = 12'h0814;
  localparam logic [11:0] CTRL_OFS = 12'h0818;
  localparam logic [11:0] STAT_OFS = 12'h081C;
  localparam logic [11:0] COEF_OFS = 12'h0840;
  localparam logic [11:0] COEF_END = 12'h0860;
  localparam int unsigned FMT_LSB     = 0;
  localparam int unsigned CCM_EN_BIT  = 4;
  localparam int unsigned SHARP_LSB   = 8;
  localparam int unsigned SET_SEL_BIT = 12;
  localparam int unsigned BUSY_BIT    = 16;

  localparam logic [8:0] HUE_RST   = 9'h080;
  localparam logic [8:0] HUE_MAX   = 9'h100;
  localparam logic [8:0] SAT_RST   = 9'h100;
  localparam logic [8:0] SAT_MAX   = 9'h1FF;
  localparam logic [2:0] SHARP_RST = 3'h2;
  localparam logic [2:0] SHARP_MAX = 3'h4;

  // ==========================================================================
  // colour correction, fixed point with 1000 meaning unity
  localparam logic signed [31:0] COEF_UNITY = 32'sh0000_03E8;
  localparam logic signed [31:0] COEF_MIN   = -32'sh0000_03E8;
  localparam logic signed [31:0] COEF_MAX   = 32'sh0000_07D0;
  localparam logic signed [31:0] ROW_MAX    = 32'sh0000_07D0;
  localparam logic signed [31:0] COEF_ZERO  = 32'sh0000_0000;
  // 1049 / 2^20 stands in for 1/1000; exact for unity gain on 8-bit data
  localparam logic signed [47:0] RECIP_1000 = 48'sh0000_0000_0419;
  localparam int unsigned        RECIP_SH   = 20;
  localparam logic signed [31:0] FACTORY_COEF [COEF_NUM] = '{
    COEF_UNITY, COEF_ZERO, COEF_ZERO,
    COEF_ZERO, COEF_UNITY, COEF_ZERO,
    COEF_ZERO, COEF_ZERO, COEF_UNITY};

  // ==========================================================================
  // rgb to yuv weights in 1/256
  localparam logic signed [9:0] Y_R = 10'sh04D;
  localparam logic signed [9:0] Y_G = 10'sh097;
  localparam logic signed [9:0] Y_B = 10'sh01C;
  localparam logic signed [9:0] U_R = -10'sh02B;
  localparam logic signed [9:0] U_G = -10'sh054;
  localparam logic signed [9:0] U_B = 10'sh07F;
  localparam logic signed [9:0] V_R = 10'sh07F;
  localparam logic signed [9:0] V_G = -10'sh06C;
  localparam logic signed [9:0] V_B = -10'sh015;
  localparam int unsigned       YUV_SH = 8;
  localparam logic signed [47:0] CHROMA_OFS = 48'sh0000_0000_0080;

  // ==========================================================================
  // hue rotation (q16 sine and cosine) and saturation (1/256)
  localparam logic signed [9:0]  HUE_MID = 10'sh080;
  localparam logic signed [47:0] SIN_K   = 48'sh0000_0000_0059;
  localparam logic signed [47:0] COS_K   = 48'sh0000_0000_007D;
  localparam int unsigned        COS_SH  = 11;
  localparam logic signed [47:0] COS_ONE = 48'sh0000_0001_0000;
  localparam int unsigned        HS_SH   = 24;

  // ==========================================================================
  // sharpness taps in eighths, index is the sharpness level
  localparam logic signed [5:0] SHARP_SIDE [5] = '{6'sh02, 6'sh01, 6'sh00, -6'sh02, -6'sh04};
  localparam logic signed [5:0] SHARP_MID  [5] = '{6'sh04, 6'sh06, 6'sh08, 6'sh0C, 6'sh10};
  localparam int unsigned       SHARP_SH = 3;

  typedef enum logic [2:0] {
    yuv_pixel_format       = 3'h0,
    direct_rgb_byte_format = 3'h1,
    mosaic_byte_format     = 3'h2,
    mosaic_packed_format   = 3'h3,
    mosaic_word_format     = 3'h4
  } fmt_t;

  typedef struct packed {
    logic                v;
    logic                sol;
    fmt_t                fmt;
    logic [11:0]         raw;
    logic signed [9:0]   c0;
    logic signed [9:0]   c1;
    logic signed [9:0]   c2;
  } pix_t;

endpackage

// file: sim/sensor_readout_model.sv
// sensor readout model: bayer lines in raster order, red pixel first
// assumes one pixel clock and a one-cycle i_go pulse while o_busy is low
`timescale 1ns/1ns
module sensor_readout_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [3:0]  i_width,
  input  wire logic [3:0]  i_lines,
  input  wire logic [11:0] i_red,
  input  wire logic [11:0] i_green,
  input  wire logic [11:0] i_blue,
  output logic             o_valid,
  output logic             o_line_start,
  output logic             o_frame_start,
  output logic      [11:0] o_data,
  output logic             o_busy
);
  initial begin
    {o_valid, o_line_start, o_frame_start, o_busy} = 4'h0;
    o_data = 12'h0000;
    forever begin
      @(posedge i_sys_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        for (int r = 0; r < i_lines; r++) begin
          for (int c = 0; c < i_width; c++) begin
            o_valid       <= 1'b1;
            o_line_start  <= (c == 0);
            o_frame_start <= (c == 0) && (r == 0);
            o_data <= r[0] ? (c[0] ? i_blue : i_green) : (c[0] ? i_green : i_red);
            @(posedge i_sys_clk);
          end
          // between lines the data bus shows no stale sample
          {o_valid, o_line_start, o_frame_start} <= 3'h0;
          o_data <= ~o_data;
          repeat (3) @(posedge i_sys_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule // sensor_readout_model

// file: sim/color_pixel_pipeline_bench.sv
// color pixel pipeline bench: register port tasks, sensor model, output capture
// assumes the design answers reads one cycle later and pixels six cycles later
`timescale 1ns/1ns
module color_pixel_pipeline_bench;
  import color_pipe_pkg::*;
  logic i_sys_clk, i_rst, i_pix_valid, i_line_start, i_frame_start, i_reg_wr, i_reg_rd;
  logic [11:0] i_pix_data, i_reg_addr, red, green, blue;
  logic [31:0] i_reg_wdata, o_reg_rdata, rv;
  logic        o_pix_valid, go, busy;
  logic [2:0]  o_pix_format;
  logic [7:0]  o_comp0, o_comp1, o_comp2;
  logic [11:0] o_raw_sample;
  logic [3:0]  width, lines;
  logic [38:0] cap [256];
  int          n_out, cyc, in_cyc, out_cyc [256], fails, samples_checked, base;
  // ==========================================================================
  // clock, instances, capture
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  color_pixel_pipeline color_pixel_pipeline_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_pix_valid(i_pix_valid), .i_line_start(i_line_start), .i_frame_start(i_frame_start),
    .i_pix_data(i_pix_data), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_pix_valid(o_pix_valid), .o_pix_format(o_pix_format), .o_comp0(o_comp0),
    .o_comp1(o_comp1), .o_comp2(o_comp2), .o_raw_sample(o_raw_sample));
  sensor_readout_model sensor_readout_model_i (.i_sys_clk(i_sys_clk), .i_go(go),
    .i_width(width), .i_lines(lines), .i_red(red), .i_green(green), .i_blue(blue),
    .o_valid(i_pix_valid), .o_line_start(i_line_start), .o_frame_start(i_frame_start),
    .o_data(i_pix_data), .o_busy(busy));
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (i_pix_valid === 1'b1) in_cyc <= cyc;
    if (o_pix_valid === 1'b1) begin
      cap[n_out[7:0]]     <= {o_pix_format, o_comp0, o_comp1, o_comp2, o_raw_sample};
      out_cyc[n_out[7:0]] <= cyc;
      n_out               <= n_out + 1;
    end
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 rv = o_reg_rdata;
  endtask
  task automatic stream(input logic [3:0] w, input logic [3:0] l, input logic [11:0] r,
                        input logic [11:0] g, input logic [11:0] b);
    base = n_out;
    @(posedge i_sys_clk);
    {width, lines, red, green, blue} <= {w, l, r, g, b};
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(posedge i_sys_clk);
      if (busy === 1'b0) break;
    end
    repeat (10) @(posedge i_sys_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset_and_clamp();
    rd(HUE_OFS);  chk("hue reset", 32'h0000_0080, rv);
    rd(SAT_OFS);  chk("sat reset", 32'h0000_0100, rv);
    rd(CTRL_OFS); chk("ctrl reset", 32'h0000_0210, rv);
    rd(12'h0850); chk("user identity", 32'h0000_03E8, rv);
    wr(12'h0900, 32'h0000_1234);
    rd(12'h0900); chk("unmapped", 32'h0000_0000, rv);
    wr(HUE_OFS, 32'h0000_012C); rd(HUE_OFS); chk("hue max", 32'h0000_0100, rv);
    wr(SAT_OFS, 32'h0000_0258); rd(SAT_OFS); chk("sat max", 32'h0000_01FF, rv);
    wr(CTRL_OFS, 32'h0000_0710); rd(CTRL_OFS); chk("sharp max", 32'h0000_0410, rv);
  endtask
  task automatic t_coef();
    wr(12'h0840, 32'h0000_0BB8); rd(12'h0840); chk("coef max", 32'h0000_07D0, rv);
    wr(12'h0844, 32'h0000_01F4); rd(12'h0844); chk("row sum", 32'h0000_0000, rv);
    wr(12'h084C, 32'hFFFF_EC78); rd(12'h084C); chk("coef min", 32'hFFFF_FC18, rv);
  endtask
  task automatic t_grey();
    wr(SAT_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0410);
    stream(4'h8, 4'h2, 12'hC80, 12'hC80, 12'hC80);
    chk("luma", 32'h0000_00C8, {24'h0, cap[base + 15][35:28]});
    chk("chroma", 32'h0000_8080, {16'h0, cap[base + 15][27:12]});
  endtask
  task automatic t_yuv();
    wr(HUE_OFS, 32'h0000_0080);
    wr(SAT_OFS, 32'h0000_0100);
    wr(CTRL_OFS, 32'h0000_0210);
    stream(4'h8, 4'h3, 12'hC80, 12'h640, 12'h320);
    chk("yuv", 32'h007C_56B4, {8'h0, cap[base + 19][35:12]});
    wr(CTRL_OFS, 32'h0000_1200);
    stream(4'h8, 4'h3, 12'hC80, 12'h640, 12'h320);
    chk("yuv no matrix", 32'h007C_56B4, {8'h0, cap[base + 19][35:12]});
    rd(STAT_OFS); chk("status", 32'h0000_0003, rv);
  endtask
  task automatic t_rgb();
    wr(CTRL_OFS, 32'h0000_0211);
    stream(4'h8, 4'h3, 12'hC80, 12'h640, 12'h320);
    chk("rgb factory", 32'h01C8_6432, {5'h0, cap[base + 19][38:12]});
    wr(CTRL_OFS, 32'h0000_1211);
    stream(4'h8, 4'h3, 12'hC80, 12'h640, 12'h320);
    chk("rgb user", 32'h01FF_0032, {5'h0, cap[base + 19][38:12]});
  endtask
  task automatic t_raw();
    wr(HUE_OFS, 32'h0000_0000);
    for (int f = 2; f <= 4; f++) begin
      wr(CTRL_OFS, 32'h0000_1400 | f);
      stream(4'h1, 4'h1, 12'hABC, 12'h000, 12'h000);
      chk("raw fmt", f, cap[base][38:36]);
      chk("raw comps", (f == 2) ? 32'h00AB_0000 : 0, cap[base][35:12]);
      chk("raw sample", 32'h0000_0ABC, cap[base][11:0]);
      chk("latency", 6, out_cyc[base] - in_cyc);
    end
  endtask
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, go} = 4'h8;
    {i_reg_addr, i_reg_wdata} = '0;
    {width, lines, red, green, blue} = '0;
    {n_out, cyc, in_cyc, fails, samples_checked, base} = '0;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset_and_clamp();
    t_coef();
    t_grey();
    t_rgb();
    t_yuv();
    t_raw();
    complete_run();
  end
endmodule // color_pixel_pipeline_bench
